// file: usb_irq_pkg.sv
package usb_irq_pkg;

  // ==========================================================================
  // Register offsets, relative to the controller's base address window
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] ENABLE_OFFSET = 8'h10;

  // ==========================================================================
  // Bit positions, shared by the flag and the enable register; MASTER_EN_BIT only in the enable register
  localparam int unsigned OVERRUN_BIT    = 0;
  localparam int unsigned DONE_BIT       = 1;
  localparam int unsigned SOF_BIT        = 2;
  localparam int unsigned RESUME_BIT     = 3;
  localparam int unsigned FATAL_BIT      = 4;
  localparam int unsigned FRAME_OVF_BIT  = 5;
  localparam int unsigned ROOT_HUB_BIT   = 6;
  localparam int unsigned OWNERSHIP_BIT  = 30;
  localparam int unsigned MASTER_EN_BIT  = 31;

  // ==========================================================================
  // Reset values and implemented-bit masks
  localparam logic [31:0] STATUS_RESET        = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET        = 32'h0000_0000;
  localparam logic [31:0] STATUS_MASK         = 32'h4000_007F;
  localparam logic [31:0] ENABLE_MASK         = 32'hC000_007F;
  localparam logic [31:0] NORMAL_SOURCE_MASK  = 32'h0000_007F;
  localparam logic [1:0]  OVERRUN_COUNT_RESET = 2'h0;
  localparam logic [1:0]  OVERRUN_COUNT_STEP  = 2'h1;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  // One-cycle pulses from the schedule engine, root hub and system side,
  // except frame_msb which is the live level of the frame counter's top bit
  typedef struct packed {
    logic ownership_change_request;
    logic root_hub_change;
    logic frame_msb;
    logic shared_frame_updated;
    logic fatal_system_error;
    logic frame_start;
    logic done_queue_written;
    logic schedule_overrun;
  } core_events_t;

endpackage

// file: usb_host_irq_status_enable.sv
`timescale 1ns/100ps
// Overview of operation
// - Each tracked event sets its status flag; it stays set until software clears it.
// - Normal interrupt requested only when flag, its enable and master enable bit 31 are set.
// - Status at 0Ch: write 1 clears, write 0 keeps; never set by write or hardware-cleared.
// - Enable at 10h: write 1 sets, write 0 keeps; read returns current enables.
// - Enable bits align with their flags; master enable bit 31 only in enable register.
// - Ownership-change flag bit 30 set when software raises ownership change request.
// - Unmasked ownership change raises the system management interrupt, not the normal one.
// - Without the system management pin the ownership-change flag is held at zero.
// - Root hub change flag bit 6 set on any root hub or port status change.
// - Frame overflow flag bit 5 set on frame counter bit 15 toggle or frame copy.
// - System error sets flag bit 4 and halts schedule processing until corrected.
// - Resume flag bit 3 set on rising edge of device-driven resume signaling.
// - Resume flag not set when software enters the resume functional state.
// - Start-of-frame flag bit 2 set together with the SOF token.
// - Done-queue flag bit 1 set after head write; no further updates until cleared.
// - Overrun sets flag bit 0 and increments the separate two-bit overrun_count_out output.
// - Two-bit overrun counter starts at 00b, wraps after 11b, counts every overrun.
module usb_host_irq_status_enable
  import usb_irq_pkg::*;
#(
  parameter bit SMI_PIN_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // Register access from the base-address window
  input  wire reg_req_t     reg_req_in,
  output logic [31:0]       reg_rdata_out,
  // Events from the controller core
  input  wire core_events_t core_events_in,
  input  wire logic         host_resume_state_in,
  // Resume signaling seen on the downstream port pins
  input  wire logic         resume_signal_in,
  // Interrupts and status towards the core
  output logic              irq_out,
  output logic              system_mgmt_irq_pin_n_out,
  output logic              schedule_halt_out,
  output logic              done_update_allow_out,
  output logic [1:0]        overrun_count_out
);

  // ==========================================================================
  // Storage
  logic [31:0] event_status_flags;
  logic [31:0] event_enable_set;
  logic [31:0] next_status;
  logic [31:0] next_enable;
  logic [31:0] status_set;
  logic [31:0] status_clear;
  logic [31:0] enable_write_set;
  logic        status_hit;
  logic        enable_hit;
  logic        frame_msb_prev;
  logic        resume_meta;
  logic        resume_sync;
  logic        resume_prev;
  logic        resume_rise;
  logic        master_on;
  logic        normal_pending;
  logic        mgmt_pending;

  assign status_hit = reg_req_in.addr == STATUS_OFFSET;
  assign enable_hit = reg_req_in.addr == ENABLE_OFFSET;
  assign master_on  = event_enable_set[MASTER_EN_BIT];

  // ==========================================================================
  // Resume pin synchroniser; the edge is taken from the second and third stages
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      resume_meta <= 1'b0;
      resume_sync <= 1'b0;
      resume_prev <= 1'b0;
    end else begin
      resume_meta <= resume_signal_in;
      resume_sync <= resume_meta;
      resume_prev <= resume_sync;
    end
  end

  // Software-entered resume is our own signaling, not a device event
  assign resume_rise = resume_sync && !resume_prev && !host_resume_state_in;

  // ==========================================================================
  // Frame counter top bit history
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      frame_msb_prev <= 1'b0;
    end else begin
      frame_msb_prev <= core_events_in.frame_msb;
    end
  end

  // ==========================================================================
  // Flag set sources
  always_comb begin
    status_set                 = STATUS_RESET;
    status_set[OVERRUN_BIT]    = core_events_in.schedule_overrun;
    status_set[DONE_BIT]       = core_events_in.done_queue_written;
    status_set[SOF_BIT]        = core_events_in.frame_start;
    status_set[RESUME_BIT]     = resume_rise;
    status_set[FATAL_BIT]      = core_events_in.fatal_system_error;
    status_set[FRAME_OVF_BIT]  = (core_events_in.frame_msb ^ frame_msb_prev)
                               | core_events_in.shared_frame_updated;
    status_set[ROOT_HUB_BIT]   = core_events_in.root_hub_change;
    status_set[OWNERSHIP_BIT]  = core_events_in.ownership_change_request
                               & SMI_PIN_PRESENT;
  end

  // Write-one-to-clear; the hardware never clears a flag on its own
  assign status_clear = (reg_req_in.wr_en && status_hit) ? reg_req_in.wdata : READ_ZERO;

  // A set arriving in the clear cycle wins, so no event is lost
  always_comb begin
    next_status = ((event_status_flags & ~status_clear) | status_set) & STATUS_MASK;
    if (!SMI_PIN_PRESENT) begin
      next_status[OWNERSHIP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      event_status_flags <= STATUS_RESET;
    end else begin
      event_status_flags <= next_status;
    end
  end

  // ==========================================================================
  // Enable register: write-one-to-set, same positions as the flags
  assign enable_write_set = (reg_req_in.wr_en && enable_hit) ? reg_req_in.wdata : READ_ZERO;
  assign next_enable      = (event_enable_set | enable_write_set) & ENABLE_MASK;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      event_enable_set <= ENABLE_RESET;
    end else begin
      event_enable_set <= next_enable;
    end
  end

  // ==========================================================================
  // Read data; unmapped offsets read as zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= READ_ZERO;
    end else if (reg_req_in.rd_en) begin
      if (status_hit) begin
        reg_rdata_out <= event_status_flags;
      end else if (enable_hit) begin
        reg_rdata_out <= event_enable_set;
      end else begin
        reg_rdata_out <= READ_ZERO;
      end
    end
  end

  // ==========================================================================
  // Interrupt outputs
  // Ownership change is routed only to the management pin, so it never
  // wakes the ordinary driver's handler
  assign normal_pending = master_on
                        && |(event_status_flags & event_enable_set & NORMAL_SOURCE_MASK);
  assign mgmt_pending   = SMI_PIN_PRESENT
                        && event_status_flags[OWNERSHIP_BIT]
                        && event_enable_set[OWNERSHIP_BIT];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out                   <= 1'b0;
      system_mgmt_irq_pin_n_out <= 1'b1;
    end else begin
      irq_out                   <= normal_pending;
      system_mgmt_irq_pin_n_out <= !mgmt_pending;
    end
  end

  // ==========================================================================
  // Controls back to the core
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      schedule_halt_out     <= 1'b0;
      done_update_allow_out <= 1'b1;
    end else begin
      // Halt persists until the flag is cleared, by a write of one or by reset
      schedule_halt_out     <= next_status[FATAL_BIT];
      done_update_allow_out <= !next_status[DONE_BIT];
    end
  end

  // Counts every overrun, even with the flag already set; wraps naturally
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_count_out <= OVERRUN_COUNT_RESET;
    end else if (core_events_in.schedule_overrun) begin
      overrun_count_out <= 2'(overrun_count_out + OVERRUN_COUNT_STEP);
    end
  end

  // ==========================================================================
  // Assertions
  property p_flag_sticky;
    @(posedge clk_sys_in) disable iff (rst_in)
      (event_status_flags[SOF_BIT] && !(reg_req_in.wr_en && status_hit
        && reg_req_in.wdata[SOF_BIT])) |=> event_status_flags[SOF_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Flag lost without clear");

  property p_irq_needs_master;
    @(posedge clk_sys_in) disable iff (rst_in)
      irq_out |-> $past(master_on) && $past(|(event_status_flags & event_enable_set
        & NORMAL_SOURCE_MASK));
  endproperty
  a_irq_needs_master: assert property (p_irq_needs_master) else $error("Irq without cause");

  property p_w1c_clears;
    @(posedge clk_sys_in) disable iff (rst_in)
      (reg_req_in.wr_en && status_hit && reg_req_in.wdata[ROOT_HUB_BIT]
        && !core_events_in.root_hub_change) |=> !event_status_flags[ROOT_HUB_BIT];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("Write one did not clear");

  property p_w1s_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (reg_req_in.wr_en && enable_hit && reg_req_in.wdata[MASTER_EN_BIT])
        |=> event_enable_set[MASTER_EN_BIT] ##1 event_enable_set[MASTER_EN_BIT];
  endproperty
  a_w1s_sets: assert property (p_w1s_sets) else $error("Enable not set or not held");

  property p_ownership_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      core_events_in.ownership_change_request |=>
        event_status_flags[OWNERSHIP_BIT] == SMI_PIN_PRESENT;
  endproperty
  a_ownership_set: assert property (p_ownership_set) else $error("Ownership flag wrong");

  property p_mgmt_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      (event_status_flags[OWNERSHIP_BIT] && event_enable_set[OWNERSHIP_BIT])
        |=> !system_mgmt_irq_pin_n_out;
  endproperty
  a_mgmt_pin: assert property (p_mgmt_pin) else $error("Management irq not raised");

  property p_frame_toggle;
    @(posedge clk_sys_in) disable iff (rst_in)
      $changed(core_events_in.frame_msb) |=> event_status_flags[FRAME_OVF_BIT];
  endproperty
  a_frame_toggle: assert property (p_frame_toggle) else $error("Frame overflow missed");

  property p_halt;
    @(posedge clk_sys_in) disable iff (rst_in)
      core_events_in.fatal_system_error |=> schedule_halt_out;
  endproperty
  a_halt: assert property (p_halt) else $error("No halt after system error");

  property p_resume_sw;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!event_status_flags[RESUME_BIT] && host_resume_state_in)
        |=> !event_status_flags[RESUME_BIT];
  endproperty
  a_resume_sw: assert property (p_resume_sw) else $error("Resume set by software state");

  property p_done_block;
    @(posedge clk_sys_in) disable iff (rst_in)
      core_events_in.done_queue_written |=> !done_update_allow_out;
  endproperty
  a_done_block: assert property (p_done_block) else $error("Done update not blocked");

  property p_overrun_count;
    @(posedge clk_sys_in) disable iff (rst_in)
      core_events_in.schedule_overrun |=>
        overrun_count_out == 2'($past(overrun_count_out) + OVERRUN_COUNT_STEP)
        && event_status_flags[OVERRUN_BIT];
  endproperty
  a_overrun_count: assert property (p_overrun_count) else $error("Overrun count wrong");

  property p_irq_level;
    @(posedge clk_sys_in) disable iff (rst_in)
      (normal_pending && !reg_req_in.wr_en) [*2] |=> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Irq dropped while pending");

  property p_root_hub_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      core_events_in.root_hub_change |=> event_status_flags[ROOT_HUB_BIT];
  endproperty
  a_root_hub_set: assert property (p_root_hub_set) else $error("Root hub change missed");

  property p_sof_by_event;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(event_status_flags[SOF_BIT]) |-> $past(core_events_in.frame_start);
  endproperty
  a_sof_by_event: assert property (p_sof_by_event) else $error("Spurious flag");

  property p_resume_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(resume_signal_in) ##2 !host_resume_state_in |=> event_status_flags[RESUME_BIT];
  endproperty
  a_resume_pin: assert property (p_resume_pin) else $error("Device resume missed");

  property p_irq_master_off;
    @(posedge clk_sys_in) disable iff (rst_in)
      !master_on |=> !irq_out;
  endproperty
  a_irq_master_off: assert property (p_irq_master_off) else $error("Irq without master");

  property p_enable_keep;
    @(posedge clk_sys_in) disable iff (rst_in)
      ($past(event_enable_set) & ~event_enable_set) == READ_ZERO;
  endproperty
  a_enable_keep: assert property (p_enable_keep) else $error("Enable bit dropped");

  property p_done_release;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!event_status_flags[DONE_BIT] && !core_events_in.done_queue_written)
        |=> done_update_allow_out;
  endproperty
  a_done_release: assert property (p_done_release) else $error("Done update held");

  property p_overrun_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      !core_events_in.schedule_overrun |=> $stable(overrun_count_out);
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("Overrun count moved");

  property p_read_enable;
    @(posedge clk_sys_in) disable iff (rst_in)
      (reg_req_in.rd_en && enable_hit) |=> reg_rdata_out == $past(event_enable_set);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("Enable read wrong");

  property p_read_status;
    @(posedge clk_sys_in) disable iff (rst_in)
      (reg_req_in.rd_en && status_hit) |=> reg_rdata_out == $past(event_status_flags);
  endproperty
  a_read_status: assert property (p_read_status) else $error("Status read wrong");

  property p_mgmt_release;
    @(posedge clk_sys_in) disable iff (rst_in)
      !event_status_flags[OWNERSHIP_BIT] |=> system_mgmt_irq_pin_n_out;
  endproperty
  a_mgmt_release: assert property (p_mgmt_release) else $error("Management irq stuck");

endmodule // usb_host_irq_status_enable

// file: usb_host_irq_status_enable_tb_top.sv
`timescale 1ns/100ps
module usb_host_irq_status_enable_tb_top;
  import usb_irq_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic         clk_sys_in;
  logic         rst_in;
  reg_req_t     req;
  core_events_t ev;
  logic         host_resume_state;
  logic         resume_signal;
  logic [31:0]  rdata;
  logic [31:0]  rdata_b;
  logic         irq;
  logic         smi_n;
  logic         halt;
  logic         allow;
  logic [1:0]   cnt;
  logic [31:0]  rd_word;
  logic [31:0]  rd_word_b;
  int           n_mismatch;
  int           checks;
  int           flag_pos [8] = '{0, 1, 2, 4, 5, 0, 6, 30};
  int           exp_cnt;

  usb_host_irq_status_enable i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .core_events_in(ev), .host_resume_state_in(host_resume_state),
    .resume_signal_in(resume_signal), .irq_out(irq), .system_mgmt_irq_pin_n_out(smi_n),
    .schedule_halt_out(halt), .done_update_allow_out(allow), .overrun_count_out(cnt));

  // Same inputs, but built without the management pin
  usb_host_irq_status_enable #(.SMI_PIN_PRESENT(1'b0)) i_dut_no_pin (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata_b),
    .core_events_in(ev), .host_resume_state_in(host_resume_state),
    .resume_signal_in(resume_signal), .irq_out(), .system_mgmt_irq_pin_n_out(),
    .schedule_halt_out(), .done_update_allow_out(), .overrun_count_out());

  // ==========================================================================
  // Clock, compare and access tasks
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic cmp_word(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp_bit(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    tick(1);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
    tick(1);
    req = '0;
  endtask

  // Read data is registered; sampling one edge after the strobe covers both latencies
  task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
    tick(1);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 32'h0000_0000};
    tick(1);
    req = '0;
    tick(1);
    data = rdata;
    rd_word_b = rdata_b;
  endtask

  // Frame counter top bit is a level, so it survives every pulse
  task automatic pulse(input core_events_t e);
    tick(1);
    ev = e | (ev & 8'h20);
    tick(1);
    ev = ev & 8'h20;
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================================
  // Tests
  initial begin
    n_mismatch = 0;
    checks = 0;
    exp_cnt = 0;
    rst_in = 1'b1;
    req = '0;
    ev = '0;
    host_resume_state = 1'b0;
    resume_signal = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    cmp_bit("irq reset", irq, 1'b0);
    cmp_bit("smi_n reset", smi_n, 1'b1);
    cmp_bit("halt reset", halt, 1'b0);
    cmp_bit("allow reset", allow, 1'b1);
    cmp_word("count reset", {30'h0, cnt}, 32'h0000_0000);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("status reset", rd_word, STATUS_RESET);
    reg_read(ENABLE_OFFSET, rd_word);
    cmp_word("enable reset", rd_word, ENABLE_RESET);
    reg_write(STATUS_OFFSET, STATUS_MASK);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("status after write ones", rd_word, 32'h0000_0000);
    // Every event except the frame_msb level alone sets only its own flag, which a write of 0 keeps
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        pulse(core_events_t'(8'h01 << i));
        if (i == 0) exp_cnt++;
        tick(3);
        reg_read(STATUS_OFFSET, rd_word);
        cmp_word("event flag", rd_word, 32'h1 << flag_pos[i]);
        cmp_word("flag without pin", rd_word_b, (i == 7) ? 32'h0 : 32'h1 << flag_pos[i]);
        cmp_bit("halt", halt, i == 3);
        cmp_bit("done allow", allow, i != 1);
        reg_write(STATUS_OFFSET, 32'h0000_0000);
        reg_read(STATUS_OFFSET, rd_word);
        cmp_word("flag after write 0", rd_word, 32'h1 << flag_pos[i]);
        if (i == 3) begin
          // Resetting the controller clears the fatal flag, the halt and the overrun count
          rst_in = 1'b1;
          tick(3);
          rst_in = 1'b0;
          exp_cnt = 0;
          cmp_bit("halt after reset", halt, 1'b0);
          cmp_word("count after reset", {30'h0, cnt}, 32'h0000_0000);
        end
        reg_write(STATUS_OFFSET, 32'h1 << flag_pos[i]);
        reg_read(STATUS_OFFSET, rd_word);
        cmp_word("flag after write 1", rd_word, 32'h0000_0000);
      end
    end
    ev.frame_msb = 1'b1;
    tick(3);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("frame msb toggle", rd_word, 32'h0000_0020);
    reg_write(STATUS_OFFSET, 32'h0000_0020);
    // A set in the very cycle of its clear survives
    tick(1);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: STATUS_OFFSET, wdata: 32'h0000_0004};
    ev.frame_start = 1'b1;
    tick(1);
    req = '0;
    ev.frame_start = 1'b0;
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("set beats clear", rd_word, 32'h0000_0004);
    reg_write(STATUS_OFFSET, 32'h0000_0004);
    ev.frame_msb = 1'b0;
    tick(3);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("frame msb fall", rd_word, 32'h0000_0020);
    reg_write(STATUS_OFFSET, 32'h0000_0020);
    // Back-to-back overruns keep counting with the flag already set
    for (int k = 0; k < 5; k++) begin
      tick(1);
      ev.schedule_overrun = 1'b1;
      exp_cnt++;
    end
    tick(1);
    ev.schedule_overrun = 1'b0;
    tick(2);
    cmp_word("overrun count", {30'h0, cnt}, 32'(exp_cnt % 4));
    reg_write(STATUS_OFFSET, 32'h0000_0001);
    // Enable register: write 1 sets, write 0 keeps; unmapped address ignored
    reg_write(ENABLE_OFFSET, 32'h0000_0004);
    reg_write(ENABLE_OFFSET, 32'h0000_0000);
    reg_write(8'h14, 32'hFFFF_FFFF);
    reg_read(ENABLE_OFFSET, rd_word);
    cmp_word("enable set", rd_word, 32'h0000_0004);
    reg_read(8'h14, rd_word);
    cmp_word("unmapped read", rd_word, READ_ZERO);
    pulse('{frame_start: 1'b1, default: 1'b0});
    pulse('{root_hub_change: 1'b1, default: 1'b0});
    tick(3);
    cmp_bit("irq without master", irq, 1'b0);
    reg_write(ENABLE_OFFSET, 32'h8000_0000);
    tick(10);
    cmp_bit("irq enabled flag", irq, 1'b1);
    reg_write(STATUS_OFFSET, 32'h0000_0004);
    tick(3);
    cmp_bit("irq with masked flag only", irq, 1'b0);
    reg_write(STATUS_OFFSET, 32'h0000_0040);
    // Ownership change goes to the management pin only
    reg_write(ENABLE_OFFSET, 32'h4000_0000);
    pulse('{ownership_change_request: 1'b1, default: 1'b0});
    tick(3);
    cmp_bit("smi_n asserted", smi_n, 1'b0);
    cmp_bit("irq on ownership", irq, 1'b0);
    reg_write(STATUS_OFFSET, 32'h4000_0000);
    tick(3);
    cmp_bit("smi_n released", smi_n, 1'b1);
    // Resume from software state is not reported; from the device it is
    host_resume_state = 1'b1;
    resume_signal = 1'b1;
    tick(6);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("software resume", rd_word, 32'h0000_0000);
    resume_signal = 1'b0;
    tick(4);
    host_resume_state = 1'b0;
    tick(2);
    resume_signal = 1'b1;
    tick(6);
    reg_read(STATUS_OFFSET, rd_word);
    cmp_word("device resume", rd_word, 32'h0000_0008);
    reg_write(ENABLE_OFFSET, ENABLE_MASK);
    reg_read(ENABLE_OFFSET, rd_word);
    cmp_word("enable all", rd_word, ENABLE_MASK);
    tick(3);
    cmp_bit("irq on resume", irq, 1'b1);
    tally_and_finish();
  end
endmodule // usb_host_irq_status_enable_tb_top
